// ==== hw/fcf_pkg.sv ====
// Purpose: shared constants of the full-cycle serial flash link
// Assumes: both ends run on one 200 MHz ref_clk
// Notes:   opcodes and status layout are local to this link
package fcf_pkg;
  // ------------------------------------------------------------
  // clock and frame
  // ------------------------------------------------------------
  localparam int CLK_NS       = 5;
  localparam int FRAME_BITS   = 32;
  localparam int OP_RX_BITS   = 8;
  localparam int CNT_W        = 24;
  // half period of the serial clock, 50 MHz keeps below 85 MHz
  localparam int SCK_HALF_CYC = 2;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int T_CS_NS        = 20;
  localparam int CS_GAP_CYC     = (T_CS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RST_US       = 10;
  localparam int T_RST_CYC      = T_RST_US * 1000 / CLK_NS;
  localparam int T_EP_TYP_MS    = 17;
  localparam int T_EP_MAX_MS    = 35;
  localparam int T_OTPP_TYP_US  = 200;
  localparam int T_OTPP_MAX_US  = 500;
  localparam int T_EP_TYP_CYC   = T_EP_TYP_MS * 1000000 / CLK_NS;
  localparam int T_EP_MAX_CYC   = T_EP_MAX_MS * 1000000 / CLK_NS;
  localparam int T_OTPP_TYP_CYC = T_OTPP_TYP_US * 1000 / CLK_NS;
  localparam int T_OTPP_MAX_CYC = T_OTPP_MAX_US * 1000 / CLK_NS;
  localparam int PAGES_PER_SECTOR = 16;

  // ------------------------------------------------------------
  // opcodes and status byte
  // ------------------------------------------------------------
  localparam logic [7:0] OP_STATUS    = 8'hA1;
  localparam logic [7:0] OP_READ      = 8'hA2;
  localparam logic [7:0] OP_BUF_WRITE = 8'hA3;
  localparam logic [7:0] OP_PAGE_PROG = 8'hA4;
  localparam logic [7:0] OP_BUF_PROG  = 8'hA5;
  localparam logic [7:0] OP_OTP_PROG  = 8'hA6;
  localparam logic [7:0] OP_REWRITE   = 8'hA7;
  localparam int STAT_READY_BIT = 7;
  localparam int STAT_MODE3_BIT = 0;

  function automatic logic fcf_is_prog(input logic [7:0] op);
    return (op == OP_PAGE_PROG) || (op == OP_BUF_PROG) ||
           (op == OP_OTP_PROG) || (op == OP_REWRITE);
  endfunction

  function automatic logic [CNT_W-1:0] fcf_prog_cyc(input logic [7:0] op,
                                                    input int unsigned ep_cyc,
                                                    input int unsigned otp_cyc);
    return (op == OP_OTP_PROG) ? CNT_W'(otp_cyc) : CNT_W'(ep_cyc);
  endfunction
endpackage

// ==== hw/fcf_link_if.sv ====
// Purpose: serial pins between host controller and flash
// Assumes: both ends clocked by the same ref_clk
// Notes:   undriven data-out line reads high, as with a pull-up
interface fcf_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  logic flash_rst_n;

  assign miso = miso_oe ? miso_o : 1'b1;

  modport host (output sck, output cs_n, output mosi, output flash_rst_n, input miso);
  modport flash (input sck, input cs_n, input mosi, input flash_rst_n,
                 output miso_o, output miso_oe);
endinterface

// ==== hw/fcf_flash_end.sv ====
// Purpose: flash end of the full-cycle serial link
// Assumes: link pins synchronous to ref_clk; 32-bit frames op/addr/data
// Notes:   busy time uses the typical figure, below the maximum
module fcf_flash_end
  import fcf_pkg::*;
#(
  parameter int unsigned T_EP_CYC   = T_EP_TYP_CYC,
  parameter int unsigned T_OTPP_CYC = T_OTPP_TYP_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  fcf_link_if.flash        link,
  input  wire logic [7:0]  rd_data,
  output logic             cmd_valid,
  output logic [7:0]       cmd_op,
  output logic [15:0]      cmd_addr,
  output logic [7:0]       cmd_data,
  output logic             busy,
  output logic             mode3
);
  typedef enum logic [2:0] {D_OFF = 3'h1, D_IDLE = 3'h2, D_SHIFT = 3'h4} fcf_dev_state_e;

  typedef struct packed {
    fcf_dev_state_e   st;
    logic             sck_p;
    logic             mosi_p;
    logic             cs_n_p;
    logic             rose;
    logic             mode3;
    logic [5:0]       rx_n;
    logic [4:0]       tx_idx;
    logic [31:0]      rx;
    logic [31:0]      tx;
    logic             miso;
    logic             oe;
    logic             busy;
    logic [CNT_W-1:0] cnt;
    logic             ev;
    logic [7:0]       op;
    logic [15:0]      addr;
    logic [7:0]       dat;
  } fcf_dev_s;

  localparam fcf_dev_s DEV_RST = '{st: D_OFF, cs_n_p: 1'b1, default: '0};

  function automatic logic [7:0] stat_byte(input logic bsy, input logic m3);
    logic [7:0] s;
    s = 8'h00;
    s[STAT_READY_BIT] = !bsy;
    s[STAT_MODE3_BIT] = m3;
    return s;
  endfunction

  fcf_dev_s   q;
  fcf_dev_s   d;
  logic       rise;
  logic       fall;
  logic [7:0] op_now;
  logic [7:0] reply;

  assign rise   = !q.sck_p && link.sck;
  assign fall   = q.sck_p && !link.sck;
  assign op_now = {q.rx[6:0], q.mosi_p};

  always_comb begin
    case (op_now)
      OP_STATUS: reply = stat_byte(q.busy, q.mode3);
      OP_READ:   reply = rd_data;
      default:   reply = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d        = q;
    d.ev     = 1'b0;
    d.sck_p  = link.sck;
    d.mosi_p = link.mosi;
    d.cs_n_p = link.cs_n;
    if (q.busy) begin
      d.cnt = q.cnt - CNT_W'(1);
      if (q.cnt == CNT_W'(1)) begin
        d.busy = 1'b0;
      end
    end
    case (q.st)
      D_OFF: begin
        if (link.flash_rst_n) begin
          d.st = D_IDLE;
        end
      end
      D_IDLE: begin
        if (q.cs_n_p && !link.cs_n) begin
          d.st     = D_SHIFT;
          d.mode3  = link.sck;
          d.rose   = 1'b0;
          d.rx_n   = 6'h00;
          d.tx_idx = 5'h00;
          d.tx     = {stat_byte(q.busy, link.sck), 24'h000000};
          // first bit is out before any clock edge
          d.miso   = d.tx[31];
          d.oe     = 1'b1;
        end
      end
      D_SHIFT: begin
        if (link.cs_n) begin
          d.st = D_IDLE;
          d.oe = 1'b0;
          if (q.rx_n == 6'(FRAME_BITS)) begin
            d.ev   = 1'b1;
            d.op   = q.rx[31:24];
            d.addr = q.rx[23:8];
            d.dat  = q.rx[7:0];
            // commands arriving while busy still raise cmd_valid but do not restart busy
            if (fcf_is_prog(q.rx[31:24]) && !q.busy) begin
              d.busy = 1'b1;
              d.cnt  = fcf_prog_cyc(q.rx[31:24], T_EP_CYC, T_OTPP_CYC);
            end
          end
        end else begin
          // sample the level held over the whole previous period
          if (rise && (q.rx_n != 6'(FRAME_BITS))) begin
            d.rx   = {q.rx[30:0], q.mosi_p};
            d.rx_n = q.rx_n + 6'h01;
            d.rose = 1'b1;
            if (q.rx_n == 6'(OP_RX_BITS - 1)) begin
              d.tx[7:0] = reply;
            end
          end
          // mode 3 opens with a falling edge that launches nothing
          if (fall && q.rose && (q.tx_idx != 5'h1F)) begin
            d.tx_idx = q.tx_idx + 5'h01;
            d.miso   = q.tx[5'h1E - q.tx_idx];
          end
        end
      end
      default: d.st = D_OFF;
    endcase
    if (!link.flash_rst_n) begin
      d.st   = D_OFF;
      d.oe   = 1'b0;
      d.busy = 1'b0;
      d.cnt  = '0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  assign link.miso_o  = q.miso;
  assign link.miso_oe = q.oe;
  assign cmd_valid    = q.ev;
  assign cmd_op       = q.op;
  assign cmd_addr     = q.addr;
  assign cmd_data     = q.dat;
  assign busy         = q.busy;
  assign mode3        = q.mode3;
endmodule

// ==== hw/fcf_host_end.sv ====
// Purpose: host controller end of the full-cycle serial link
// Assumes: link pins synchronous to ref_clk; 32-bit frames op/addr/data
// Notes:   programs are timed out at their maximum, not polled
//
// Contract
// - flash launches on fall, samples on rise
// - host samples at the following falling edge
// - host launches its bits on rising edges
// - whole clock period per bit, both directions
// - clock level at select fall picks mode
// - basic timing: output valid during low phase
// - full-cycle timing: output may settle later
// - select high before flash reset release
// - page erase-program typical 17, max 35 ms
// - security register program 200 typ, 500 us
// - direct page program or buffer then program
// - refresh every sector page within 50,000 ops
// - rewrite command at the kept page pointer
// - select high at least 20 ns between commands
module fcf_host_end
  import fcf_pkg::*;
#(
  parameter int unsigned T_EP_CYC   = T_EP_MAX_CYC,
  parameter int unsigned T_OTPP_CYC = T_OTPP_MAX_CYC,
  parameter int unsigned PAGES      = PAGES_PER_SECTOR
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        mode3_sel,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [7:0]  cmd_op,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [7:0]  cmd_data,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic [15:0]      rewrite_ptr,
  fcf_link_if.host         link
);
  typedef enum logic [7:0] {
    H_RST  = 8'h01,
    H_IDLE = 8'h02,
    H_LEAD = 8'h04,
    H_HIGH = 8'h08,
    H_LOW  = 8'h10,
    H_TAIL = 8'h20,
    H_GAP  = 8'h40,
    H_WAIT = 8'h80
  } fcf_host_state_e;

  typedef struct packed {
    fcf_host_state_e  st;
    logic             sck;
    logic             cs_n;
    logic             mosi;
    logic             rst_n;
    logic             m3;
    logic [5:0]       bits;
    logic [31:0]      tx;
    logic [31:0]      rx;
    logic [CNT_W-1:0] cnt;
    logic [7:0]       op;
    logic             rw_pend;
    logic [15:0]      ptr;
    logic             rsp_v;
    logic [7:0]       rsp;
  } fcf_host_s;

  localparam fcf_host_s HOST_RST = '{st: H_RST, cs_n: 1'b1, default: '0};

  fcf_host_s   q;
  fcf_host_s   d;
  logic        half_done;
  logic        go;
  logic [31:0] word;

  assign half_done = (q.cnt == CNT_W'(SCK_HALF_CYC - 1));
  // a frame only opens once the idle clock already sits at the mode level
  assign cmd_ready = (q.st == H_IDLE) && !q.rw_pend && (q.sck == mode3_sel);
  assign go        = (q.st == H_IDLE) && (q.sck == mode3_sel) && (q.rw_pend || cmd_valid);
  assign word      = q.rw_pend ? {OP_REWRITE, q.ptr, 8'h00} : {cmd_op, cmd_addr, cmd_data};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d       = q;
    d.rsp_v = 1'b0;
    case (q.st)
      H_RST: begin
        // flash held in reset with select high until released
        d.cs_n = 1'b1;
        d.cnt  = q.cnt + CNT_W'(1);
        if (q.cnt == CNT_W'(T_RST_CYC - 1)) begin
          d.rst_n = 1'b1;
          d.cnt   = '0;
          d.st    = H_IDLE;
        end
      end
      H_IDLE: begin
        d.sck = mode3_sel;
        d.m3  = mode3_sel;
        if (go) begin
          // clock level at this select edge fixes mode 0 or 3
          d.cs_n = 1'b0;
          d.tx   = word;
          d.mosi = word[31];
          d.op   = word[31:24];
          d.bits = 6'h00;
          d.cnt  = '0;
          d.st   = q.m3 ? H_LEAD : H_LOW;
          if (q.rw_pend) begin
            d.rw_pend = 1'b0;
            d.ptr     = (q.ptr == 16'(PAGES - 1)) ? 16'h0000 : q.ptr + 16'h0001;
          end else if ((cmd_op == OP_PAGE_PROG) || (cmd_op == OP_BUF_PROG)) begin
            // each page write pays for one refresh at the pointer
            d.rw_pend = 1'b1;
          end
        end
      end
      H_LEAD: begin
        // mode 3 dummy falling edge: nothing captured
        d.cnt = q.cnt + CNT_W'(1);
        if (half_done) begin
          d.cnt = '0;
          d.sck = 1'b0;
          d.st  = H_LOW;
        end
      end
      H_LOW: begin
        d.cnt = q.cnt + CNT_W'(1);
        if (half_done) begin
          d.cnt  = '0;
          d.sck  = 1'b1;
          d.tx   = {q.tx[30:0], 1'b0};
          d.mosi = q.tx[30];
          d.st   = H_HIGH;
        end
      end
      H_HIGH: begin
        d.cnt = q.cnt + CNT_W'(1);
        if (half_done) begin
          d.cnt  = '0;
          d.sck  = 1'b0;
          // bit launched one falling edge ago
          d.rx   = {q.rx[30:0], link.miso};
          d.bits = q.bits + 6'h01;
          d.st   = (q.bits == 6'(FRAME_BITS - 1)) ? H_TAIL : H_LOW;
        end
      end
      H_TAIL: begin
        d.cnt = q.cnt + CNT_W'(1);
        if (half_done) begin
          d.cnt   = '0;
          d.sck   = q.m3;
          d.cs_n  = 1'b1;
          d.rsp_v = 1'b1;
          d.rsp   = q.rx[7:0];
          d.st    = H_GAP;
        end
      end
      H_GAP: begin
        d.cnt = q.cnt + CNT_W'(1);
        if (q.cnt == CNT_W'(CS_GAP_CYC - 1)) begin
          if (fcf_is_prog(q.op)) begin
            d.cnt = fcf_prog_cyc(q.op, T_EP_CYC, T_OTPP_CYC);
            d.st  = H_WAIT;
          end else begin
            d.cnt = '0;
            d.st  = H_IDLE;
          end
        end
      end
      H_WAIT: begin
        d.cnt = q.cnt - CNT_W'(1);
        if (q.cnt == CNT_W'(1)) begin
          d.cnt = '0;
          d.st  = H_IDLE;
        end
      end
      default: d.st = H_RST;
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  assign link.sck         = q.sck;
  assign link.cs_n        = q.cs_n;
  assign link.mosi        = q.mosi;
  assign link.flash_rst_n = q.rst_n;
  assign rsp_valid        = q.rsp_v;
  assign rsp_data         = q.rsp;
  assign rewrite_ptr      = q.ptr;
endmodule

// ==== testbench/fcf_link_chk.sv ====
// Purpose: wire checks on the serial link between both ends
// Assumes: one ref_clk domain, reset_n async active low
// Notes:   flash lags host edges by one ref_clk
module fcf_link_chk (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic flash_rst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // rising edges counted within a frame
  // ------------------------------------------------------------
  logic [5:0] rise_q;
  logic       sck_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_q <= 6'h00;
      sck_q  <= 1'b0;
    end else begin
      sck_q  <= sck;
      rise_q <= cs_n ? 6'h00 : rise_q + 6'(sck && !sck_q);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_launch_on_low: assert property (
    $changed(miso_o) && miso_oe && $past(miso_oe) |-> !sck)
    else $error("flash data changed while clock high");
  a_oe_on_select: assert property (
    $fell(cs_n) |-> ##[1:2] miso_oe)
    else $error("flash did not drive after select");
  a_flash_hold: assert property (
    $changed(miso_o) && miso_oe && $past(miso_oe) |=> ($stable(miso_o) || !miso_oe)[*3])
    else $error("flash data held less than a period");
  a_host_launch: assert property (
    !cs_n && $past(!cs_n) && $changed(mosi) |-> $rose(sck))
    else $error("host data changed off a rising edge");
  a_half_period: assert property (
    $changed(sck) && !cs_n |-> $past(sck, 2) == $past(sck))
    else $error("clock phase shorter than two cycles");
  a_bit_count: assert property (
    $rose(cs_n) |-> rise_q == 6'h20)
    else $error("frame without 32 rising edges");
  a_mode0_start: assert property (
    $fell(cs_n) && !sck |=> !sck ##1 sck)
    else $error("mode 0 frame start wrong");
  a_mode3_start: assert property (
    $fell(cs_n) && sck |=> sck ##1 !sck)
    else $error("mode 3 frame start wrong");
  a_reset_order: assert property (
    $rose(flash_rst_n) |-> cs_n && $past(cs_n))
    else $error("flash reset released with select low");
  a_select_gap: assert property (
    $rose(cs_n) |-> cs_n[*4])
    else $error("select high gap too short");
  c_mode0: cover property ($fell(cs_n) && !sck);
  c_mode3: cover property ($fell(cs_n) && sck);
  c_rst_rel: cover property ($rose(flash_rst_n));
endmodule

// ==== testbench/full_cycle_serial_flash_interface_tb.sv ====
// Purpose: host and flash ends joined, user-side tests
// Assumes: 200 MHz ref_clk, program times cut down
// Notes:   flash busy time kept below host wait
module full_cycle_serial_flash_interface_tb
  import fcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // design and stimulus
  // ------------------------------------------------------------
  localparam int EP  = 40;
  localparam int OTP = 20;
  localparam int PG  = 4;
  logic        ref_clk      = 1'b0;
  logic        reset_n      = 1'b0;
  logic        mode3_sel    = 1'b0;
  logic        cmd_valid    = 1'b0;
  logic [7:0]  cmd_op       = 8'h00;
  logic [15:0] cmd_addr     = 16'h0000;
  logic [7:0]  cmd_data     = 8'h00;
  logic [7:0]  rd_data      = 8'h00;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic [15:0] rewrite_ptr;
  logic        f_valid;
  logic [7:0]  f_op;
  logic [15:0] f_addr;
  logic [7:0]  f_data;
  logic        f_busy;
  logic        f_mode3;
  logic [23:0] f_log[$];
  int          failures     = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  int          wt;

  fcf_link_if i_fcf_link_if ();
  fcf_host_end #(.T_EP_CYC(EP), .T_OTPP_CYC(OTP), .PAGES(PG)) i_fcf_host_end (
    .ref_clk, .reset_n, .mode3_sel, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr,
    .cmd_data, .rsp_valid, .rsp_data, .rewrite_ptr, .link(i_fcf_link_if));
  fcf_flash_end #(.T_EP_CYC(30), .T_OTPP_CYC(15)) i_fcf_flash_end (
    .ref_clk, .reset_n, .link(i_fcf_link_if), .rd_data, .cmd_valid(f_valid),
    .cmd_op(f_op), .cmd_addr(f_addr), .cmd_data(f_data), .busy(f_busy), .mode3(f_mode3));
  fcf_link_chk i_fcf_link_chk (
    .ref_clk, .reset_n, .sck(i_fcf_link_if.sck), .cs_n(i_fcf_link_if.cs_n),
    .mosi(i_fcf_link_if.mosi), .miso_o(i_fcf_link_if.miso_o),
    .miso_oe(i_fcf_link_if.miso_oe), .flash_rst_n(i_fcf_link_if.flash_rst_n));

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (f_valid === 1'b1) f_log.push_back({f_op, f_addr});
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one request held until taken, then its answer awaited
  task automatic send(input logic [7:0] op, input logic [15:0] addr, input logic [7:0] dat);
    logic rdy;
    int   n;
    cmd_op    = op;
    cmd_addr  = addr;
    cmd_data  = dat;
    cmd_valid = 1'b1;
    wt = 0;
    do begin
      // ready as the host sees it at this very edge
      @(posedge ref_clk);
      rdy = cmd_ready;
      #1;
      wt++;
    end while (rdy !== 1'b1 && wt < 5000);
    cmd_valid = 1'b0;
    chk("taken", 24'(rdy), 24'h1);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("answer", 24'(rsp_valid), 24'h1);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  initial begin
    int i;
    int m;
    int n;
    repeat (8) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    @(posedge ref_clk);
    #1;
    chk("rst_pins", 24'({i_fcf_link_if.flash_rst_n, i_fcf_link_if.cs_n}), 24'h1);
    $display("test reset done");
    for (m = 0; m < 2; m++) begin
      mode3_sel = m[0];
      rd_data = m[0] ? 8'h96 : 8'h3C;
      send(OP_STATUS, 16'h1234, 8'h00);
      chk("status", 24'(rsp_data), 24'(8'h80 | 8'(m)));
      chk("mode", 24'(f_mode3), 24'(m));
      send(OP_READ, 16'hC3A5, 8'h5A);
      chk("read", 24'(rsp_data), 24'(rd_data));
      chk("f_cmd", {f_op, f_addr}, {OP_READ, 16'hC3A5});
      chk("f_data", 24'(f_data), 24'h5A);
    end
    $display("test modes done");
    for (i = 0; i <= PG; i++) begin
      if (i[0]) send(OP_BUF_WRITE, 16'(i * 3 + 5), 8'(i));
      send(i[0] ? OP_BUF_PROG : OP_PAGE_PROG, 16'(i * 3 + 5), 8'(i));
      chk("busy", 24'(f_busy), 24'h1);
      send(OP_STATUS, 16'h0000, 8'h00);
      n = f_log.size();
      chk("prog_wait", 24'(wt >= 2 * EP + 120), 24'h1);
      chk("ready", 24'(rsp_data), 24'h81);
      chk("rewrite", f_log[n - 2], {OP_REWRITE, 16'(i % PG)});
      chk("prog", 24'(f_log[n - 3][23:16]), 24'(i[0] ? OP_BUF_PROG : OP_PAGE_PROG));
      chk("ptr", 24'(rewrite_ptr), 24'((i + 1) % PG));
    end
    $display("test program done");
    send(OP_OTP_PROG, 16'h0040, 8'hA5);
    send(OP_STATUS, 16'h0000, 8'h00);
    chk("otp_wait", 24'(wt >= OTP - 4 && wt < EP), 24'h1);
    chk("otp_ready", 24'(rsp_data), 24'h81);
    chk("otp_ptr", 24'(rewrite_ptr), 24'((PG + 1) % PG));
    chk("frames", 24'(f_log.size()), 24'h17);
    $display("test otp done");
    test_done();
  end
endmodule
